//--- hw/pacd_pkg.sv
// How it works
// R1: Measurement-length code 0..7 counts 1,2,4,8,32,64,128,256 reference divider cycles.
// R2: Software picks a length code so each measurement lasts over 4 us.
// R3: Software avoids length code 1 when the reference divider ratio is one.
// R4: Calibration-disable bit 0 runs automatic calibration; 1 skips it entirely.
// R5: Calibration clock is reference divided by 1, 4, 16 or 32; keep it <=50 MHz.
// R6: Relock bit set gives exactly one relock attempt after lock loss; cleared gives none.
// R7: Phase-select bit swaps phase detector polarity for negative-slope or inverting loops.
// R8: Up output is driven only while its enable bit is set; resets to 1.
// R9: Down output is driven only while its enable bit is set; resets to 1.
// R10: Force-up holds up on unless force-down too; force-down likewise unless force-up.
// R11: Force-mid-rail parks the pump only when neither force-up nor force-down is set.
// R12: Software writes zeros to the two reserved bits above the down enable.
// R13: Channel count 0 disables exact frequency, 1 is invalid, 2 and up are valid.
// R14: Software loads comparison frequency over correction rate as an integer count.
// R15: Exact frequency works only with modulator type B; otherwise count must be zero.
// R16: Every field resets to its default and keeps the last written value.
package pacd_pkg;

  // ==========================================================================
  // Register map
  localparam int          ADDR_W     = 5;
  localparam int          DATA_W     = 24;
  localparam int          NUM_REGS   = 3;
  localparam logic [4:0]  ADDR_CAL   = 5'h0a;
  localparam logic [4:0]  ADDR_PD    = 5'h0b;
  localparam logic [4:0]  ADDR_EXACT = 5'h0c;
  localparam logic [1:0]  IDX_CAL    = 2'h0;
  localparam logic [1:0]  IDX_PD     = 2'h1;
  localparam logic [1:0]  IDX_EXACT  = 2'h2;
  localparam logic [1:0]  IDX_NONE   = 2'h3;
  localparam logic [23:0] RST_CAL    = 24'h002046;
  localparam logic [23:0] RST_PD     = 24'h078061;
  localparam logic [23:0] RST_EXACT  = 24'h000000;
  localparam logic [23:0] RST_TABLE [0:2] = '{RST_CAL, RST_PD, RST_EXACT};

  // ==========================================================================
  // Field layouts
  typedef struct packed {
    logic [5:0] rsvdHigh;
    logic       relockOnce;
    logic [1:0] rsvdMid;
    logic [1:0] calClockSel;
    logic       rsvdBit12;
    logic       calDisable;
    logic [7:0] rsvdLow;
    logic [2:0] measureLength;
  } pacd_cal_type;

  typedef struct packed {
    logic [11:0] rsvdHigh;
    logic        forceMidRail;
    logic        forceDown;
    logic        forceUp;
    logic [1:0]  rsvdMid;
    logic        downEnable;
    logic        upEnable;
    logic        phaseInvert;
    logic [3:0]  rsvdLow;
  } pacd_pd_type;

  // ==========================================================================
  // Timing and lookup constants
  localparam logic [8:0] MEAS_TABLE [0:7] = '{9'h001, 9'h002, 9'h004, 9'h008,
                                             9'h020, 9'h040, 9'h080, 9'h100};
  localparam logic [4:0] DIV_TABLE [0:3] = '{5'h00, 5'h03, 5'h0f, 5'h1f};
  localparam logic [23:0] CHAN_OFF     = 24'h000000;
  localparam logic [23:0] CHAN_INVALID = 24'h000001;
  localparam int CLK_PERIOD_NS   = 8;
  localparam int MEAS_MIN_NS     = 4000;
  localparam int MEAS_MIN_CYCLES = (MEAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_CLK_MAX_MHZ = 50;

  // ==========================================================================
  // State encodings
  typedef enum logic [2:0] {
    RELOCK_LOCKED = 3'h1,
    RELOCK_TRYING = 3'h2,
    RELOCK_SPENT  = 3'h4
  } pacd_relock_type;

  typedef enum logic [1:0] {
    MEAS_IDLE  = 2'h1,
    MEAS_COUNT = 2'h2
  } pacd_meas_type;

endpackage

//--- hw/pacd_reg_store.sv
`timescale 1ns/1ns
module pacd_reg_store #(
  parameter int NUM_WORDS = 3
) (
  input  wire logic                            clk_sys,
  input  wire logic                            rst_b,
  input  wire logic                            wrEn,
  input  wire logic [1:0]                      wrIdx,
  input  wire logic [23:0]                     wrData,
  input  wire logic                            rdEn,
  input  wire logic [1:0]                      rdIdx,
  output logic      [23:0]                     rdData,
  output logic                                 rdValid,
  output logic      [NUM_WORDS*24-1:0]         words
);

  if (NUM_WORDS < 1 || NUM_WORDS > 3)
    $error("pacd_reg_store: NUM_WORDS must be 1 to 3");

  logic [23:0] word_reg  [0:NUM_WORDS-1];
  logic [23:0] word_next [0:NUM_WORDS-1];
  logic [23:0] rdData_reg;
  logic [23:0] rdData_next;
  logic        rdValid_reg;
  logic        rdValid_next;

  // ==========================================================================
  // Storage words
  for (genvar i = 0; i < NUM_WORDS; i++)
  begin : g_word
    always_comb
    begin
      word_next[i] = word_reg[i];
      if (wrEn && (wrIdx == 2'(i)))
        word_next[i] = wrData; // R16
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
      if (!rst_b)
        word_reg[i] <= pacd_pkg::RST_TABLE[i]; // R16
      else
        word_reg[i] <= word_next[i];
    end

    assign words[i*24 +: 24] = word_reg[i];
  end

  // ==========================================================================
  // Registered read port; unmapped index reads zero
  always_comb
  begin
    rdValid_next = rdEn;
    rdData_next  = 24'h000000;
    for (int j = 0; j < NUM_WORDS; j++)
    begin
      if (rdEn && (rdIdx == j[1:0]))
        rdData_next = word_reg[j];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdData_reg  <= 24'h000000;
      rdValid_reg <= 1'b0;
    end
    else
    begin
      rdData_reg  <= rdData_next;
      rdValid_reg <= rdValid_next;
    end
  end

  assign rdData  = rdData_reg;
  assign rdValid = rdValid_reg;

endmodule

//--- hw/pacd_config.sv
`timescale 1ns/1ns
module pacd_config (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [4:0]  regAddr,
  input  wire logic [23:0] regWrData,
  output logic      [23:0] regRdData,
  output logic             regRdValid,
  input  wire logic        pfdUpRaw,
  input  wire logic        pfdDownRaw,
  input  wire logic        lockLost,
  input  wire logic        lockRegained,
  input  wire logic        measStart,
  input  wire logic        refDivTick,
  input  wire logic        modulatorTypeB,
  output logic             detectorUpOutput,
  output logic             detectorDownOutput,
  output logic             pumpMidRail,
  output logic             calClockTick,
  output logic             calEnable,
  output logic             measBusy,
  output logic             measDone,
  output logic             relockRequest,
  output logic             exactFreqEnable,
  output logic             exactFreqInvalid,
  output logic      [23:0] channelCount
);

  // ==========================================================================
  // Address decode and register store
  logic [1:0]  regIdx;
  logic [71:0] words;
  always_comb
  begin
    case (regAddr)
      pacd_pkg::ADDR_CAL:   regIdx = pacd_pkg::IDX_CAL;
      pacd_pkg::ADDR_PD:    regIdx = pacd_pkg::IDX_PD;
      pacd_pkg::ADDR_EXACT: regIdx = pacd_pkg::IDX_EXACT;
      default:              regIdx = pacd_pkg::IDX_NONE;
    endcase
  end
  // Writes to unmapped addresses are dropped by the store's index check
  pacd_reg_store #(
    .NUM_WORDS (pacd_pkg::NUM_REGS)
  ) u_store (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .wrEn    (regWrEn),
    .wrIdx   (regIdx),
    .wrData  (regWrData),
    .rdEn    (regRdEn),
    .rdIdx   (regIdx),
    .rdData  (regRdData),
    .rdValid (regRdValid),
    .words   (words)
  );
  pacd_pkg::pacd_cal_type calCfg;
  pacd_pkg::pacd_pd_type  pdCfg;
  logic [23:0]            chanCfg;
  assign calCfg  = pacd_pkg::pacd_cal_type'(words[0 +: 24]);
  assign pdCfg   = pacd_pkg::pacd_pd_type'(words[24 +: 24]);
  assign chanCfg = words[48 +: 24];

  // ==========================================================================
  // Calibration clock divider
  logic [4:0] divCnt_reg;
  logic [4:0] divCnt_next;
  logic       calClockTick_reg;
  logic       calClockTick_next;
  logic       calEnable_reg;
  logic       calEnable_next;
  always_comb
  begin
    calEnable_next    = ~calCfg.calDisable; // R4
    calClockTick_next = 1'b0;
    divCnt_next       = divCnt_reg + 5'h01;
    // A shrinking divisor mid-count restarts cleanly instead of wrapping
    if (divCnt_reg >= pacd_pkg::DIV_TABLE[calCfg.calClockSel]) // R5
    begin
      divCnt_next       = 5'h00;
      calClockTick_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      divCnt_reg       <= 5'h00;
      calClockTick_reg <= 1'b0;
      calEnable_reg    <= 1'b0;
    end
    else
    begin
      divCnt_reg       <= divCnt_next;
      calClockTick_reg <= calClockTick_next;
      calEnable_reg    <= calEnable_next;
    end
  end

  // ==========================================================================
  // Frequency measurement window
  pacd_pkg::pacd_meas_type measState_reg;
  pacd_pkg::pacd_meas_type measState_next;
  logic [8:0]              measCnt_reg;
  logic [8:0]              measCnt_next;
  logic [8:0]              measTarget_reg;
  logic [8:0]              measTarget_next;
  logic                    measDone_reg;
  logic                    measDone_next;
  logic                    measBusy_reg;
  logic                    measBusy_next;
  always_comb
  begin
    measState_next  = measState_reg;
    measCnt_next    = measCnt_reg;
    measTarget_next = measTarget_reg;
    measDone_next   = 1'b0;
    case (measState_reg)
      pacd_pkg::MEAS_IDLE:
      begin
        // Disabled calibration never opens a window
        if (measStart && !calCfg.calDisable) // R4
        begin
          measTarget_next = pacd_pkg::MEAS_TABLE[calCfg.measureLength]; // R1
          measCnt_next    = 9'h000;
          measState_next  = pacd_pkg::MEAS_COUNT;
        end
      end
      pacd_pkg::MEAS_COUNT:
      begin
        if (refDivTick)
        begin
          measCnt_next = measCnt_reg + 9'h001;
          if (measCnt_next == measTarget_reg) // R1
          begin
            measDone_next  = 1'b1;
            measState_next = pacd_pkg::MEAS_IDLE;
          end
        end
      end
      default: measState_next = pacd_pkg::MEAS_IDLE;
    endcase
    measBusy_next = (measState_next == pacd_pkg::MEAS_COUNT);
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      measState_reg  <= pacd_pkg::MEAS_IDLE;
      measCnt_reg    <= 9'h000;
      measTarget_reg <= 9'h000;
      measDone_reg   <= 1'b0;
      measBusy_reg   <= 1'b0;
    end
    else
    begin
      measState_reg  <= measState_next;
      measCnt_reg    <= measCnt_next;
      measTarget_reg <= measTarget_next;
      measDone_reg   <= measDone_next;
      measBusy_reg   <= measBusy_next;
    end
  end

  // ==========================================================================
  // Relock: one attempt per loss of lock
  pacd_pkg::pacd_relock_type relockState_reg;
  pacd_pkg::pacd_relock_type relockState_next;
  logic                      relockRequest_reg;
  logic                      relockRequest_next;
  always_comb
  begin
    relockState_next   = relockState_reg;
    relockRequest_next = 1'b0;
    case (relockState_reg)
      pacd_pkg::RELOCK_LOCKED:
      begin
        if (lockLost && calCfg.relockOnce) // R6
        begin
          relockRequest_next = 1'b1;
          relockState_next   = pacd_pkg::RELOCK_TRYING;
        end
        else if (lockLost)
          relockState_next = pacd_pkg::RELOCK_SPENT; // R6
      end
      pacd_pkg::RELOCK_TRYING:
      begin
        // A second failure during the attempt is not retried
        if (lockRegained)
          relockState_next = pacd_pkg::RELOCK_LOCKED;
        else if (lockLost)
          relockState_next = pacd_pkg::RELOCK_SPENT; // R6
      end
      pacd_pkg::RELOCK_SPENT:
      begin
        if (lockRegained)
          relockState_next = pacd_pkg::RELOCK_LOCKED;
      end
      default: relockState_next = pacd_pkg::RELOCK_LOCKED;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      relockState_reg   <= pacd_pkg::RELOCK_LOCKED;
      relockRequest_reg <= 1'b0;
    end
    else
    begin
      relockState_reg   <= relockState_next;
      relockRequest_reg <= relockRequest_next;
    end
  end

  // ==========================================================================
  // Phase detector, charge pump and exact frequency outputs
  logic        pdUp;
  logic        pdDown;
  logic        forceUpOnly;
  logic        forceDownOnly;
  logic        midRail;
  logic        upOut_next;
  logic        downOut_next;
  logic        upOut_reg;
  logic        downOut_reg;
  logic        midRail_reg;
  logic        exactEn_next;
  logic        exactBad_next;
  logic        exactEn_reg;
  logic        exactBad_reg;
  logic [23:0] chan_reg;
  always_comb
  begin
    pdUp          = pdCfg.phaseInvert ? pfdDownRaw : pfdUpRaw; // R7
    pdDown        = pdCfg.phaseInvert ? pfdUpRaw : pfdDownRaw; // R7
    forceUpOnly   = pdCfg.forceUp & ~pdCfg.forceDown; // R10
    forceDownOnly = pdCfg.forceDown & ~pdCfg.forceUp; // R10
    midRail       = pdCfg.forceMidRail & ~pdCfg.forceUp & ~pdCfg.forceDown; // R11
    upOut_next    = 1'b0;
    downOut_next  = 1'b0;
    if (forceUpOnly)
      upOut_next = 1'b1;
    else if (forceDownOnly)
      downOut_next = 1'b1;
    else if (!midRail)
    begin
      upOut_next   = pdUp;
      downOut_next = pdDown;
    end
    // Enables gate forced levels too, so a disabled side stays quiet
    upOut_next   = upOut_next & pdCfg.upEnable; // R8
    downOut_next = downOut_next & pdCfg.downEnable; // R9
    exactBad_next = (chanCfg == pacd_pkg::CHAN_INVALID); // R13
    // Only active with modulator type B and a valid count
    exactEn_next  = modulatorTypeB && (chanCfg != pacd_pkg::CHAN_OFF) && !exactBad_next; // R15
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      upOut_reg   <= 1'b0;
      downOut_reg <= 1'b0;
      midRail_reg <= 1'b0;
      exactEn_reg  <= 1'b0;
      exactBad_reg <= 1'b0;
      chan_reg     <= pacd_pkg::RST_EXACT;
    end
    else
    begin
      upOut_reg   <= upOut_next;
      downOut_reg <= downOut_next;
      midRail_reg <= midRail;
      exactEn_reg  <= exactEn_next;
      exactBad_reg <= exactBad_next;
      chan_reg     <= chanCfg;
    end
  end

  assign calClockTick       = calClockTick_reg;
  assign calEnable          = calEnable_reg;
  assign measBusy           = measBusy_reg;
  assign measDone           = measDone_reg;
  assign relockRequest      = relockRequest_reg;
  assign detectorUpOutput   = upOut_reg;
  assign detectorDownOutput = downOut_reg;
  assign pumpMidRail        = midRail_reg;
  assign exactFreqEnable    = exactEn_reg;
  assign exactFreqInvalid   = exactBad_reg;
  assign channelCount       = chan_reg;

endmodule

//--- tb/pacd_config_monitor.sv
`timescale 1ns/1ns
// ====================
// Port checker
module pacd_config_monitor (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [4:0]  regAddr,
  input wire logic [23:0] regWrData,
  input wire logic [23:0] regRdData,
  input wire logic        regRdValid,
  input wire logic        lockLost,
  input wire logic        refDivTick,
  input wire logic        modulatorTypeB,
  input wire logic        calEnable,
  input wire logic        measBusy,
  input wire logic        measDone,
  input wire logic        relockRequest,
  input wire logic        exactFreqEnable,
  input wire logic        exactFreqInvalid,
  input wire logic [23:0] channelCount
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic wrCal;
  logic wrExact;
  logic wrDisBit;
  logic unmapped;
  assign wrCal    = regWrEn && regAddr == pacd_pkg::ADDR_CAL;
  assign wrExact  = regWrEn && regAddr == pacd_pkg::ADDR_EXACT;
  assign wrDisBit = regWrData[11];
  assign unmapped = regAddr < pacd_pkg::ADDR_CAL || regAddr > pacd_pkg::ADDR_EXACT;

  property p_read_answer; regRdEn |=> regRdValid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_no_stray; !regRdEn |=> !regRdValid; endproperty
  a_no_stray: assert property (p_no_stray) else $error("stray read valid");
  property p_unmapped; regRdEn && unmapped |=> regRdData == 24'h000000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_cal_dis; wrCal |-> ##2 calEnable == !$past(wrDisBit, 2); endproperty
  a_cal_dis: assert property (p_cal_dis) else $error("cal enable wrong");
  property p_chan; wrExact |-> ##2 channelCount == $past(regWrData, 2); endproperty
  a_chan: assert property (p_chan) else $error("channel count wrong");
  property p_inval;
    wrExact |-> ##2 exactFreqInvalid == ($past(regWrData, 2) == 24'h000001);
  endproperty
  a_inval: assert property (p_inval) else $error("invalid flag wrong");
  property p_exact;
    wrExact |-> ##2 exactFreqEnable == ($past(modulatorTypeB) && $past(regWrData, 2) > 24'h1);
  endproperty
  a_exact: assert property (p_exact) else $error("exact enable wrong");
  property p_meas; measDone |-> $past(refDivTick) && !measBusy; endproperty
  a_meas: assert property (p_meas) else $error("measure done untimely");
  property p_relock; relockRequest |-> $past(lockLost) ##1 !relockRequest; endproperty
  a_relock: assert property (p_relock) else $error("relock request untimely");
  c_meas: cover property (measDone);
  c_relock: cover property (relockRequest);
  c_unmapped: cover property (regRdEn && unmapped);
endmodule

bind pacd_config pacd_config_monitor pacd_config_monitor_i (
  .clk_sys, .rst_b, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .regRdValid,
  .lockLost, .refDivTick, .modulatorTypeB, .calEnable, .measBusy, .measDone,
  .relockRequest, .exactFreqEnable, .exactFreqInvalid, .channelCount
);

//--- tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  // ====================
  // Signals
  logic        clk_sys, rst_b, regWrEn, regRdEn, pfdUpRaw, pfdDownRaw, seen;
  logic        lockLost, lockRegained, measStart, refDivTick, modulatorTypeB;
  logic        regRdValid, detectorUpOutput, detectorDownOutput, pumpMidRail;
  logic        calClockTick, calEnable, measBusy, measDone, relockRequest;
  logic        exactFreqEnable, exactFreqInvalid;
  logic [4:0]  regAddr;
  logic [23:0] regWrData, regRdData, channelCount, rdWord, w;
  logic [31:0] rnd;
  int          err_count, samples_checked, n, i, m;
  int          divs [0:3] = '{64, 16, 4, 2};

  pacd_config pacd_config_i (
    .clk_sys, .rst_b, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .regRdValid,
    .pfdUpRaw, .pfdDownRaw, .lockLost, .lockRegained, .measStart, .refDivTick,
    .modulatorTypeB, .detectorUpOutput, .detectorDownOutput, .pumpMidRail, .calClockTick,
    .calEnable, .measBusy, .measDone, .relockRequest, .exactFreqEnable, .exactFreqInvalid,
    .channelCount
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ====================
  // Expectations
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // Forces act after the polarity swap; the enables gate the forced levels too
  function automatic logic [23:0] pump_exp(input logic [23:0] x, input logic u, input logic d);
    pacd_pkg::pacd_pd_type p;
    logic a, b, mid;
    p = x;
    a = p.phaseInvert ? d : u;
    b = p.phaseInvert ? u : d;
    mid = 1'b0;
    if (p.forceUp && !p.forceDown)
      {a, b} = 2'b10;
    else if (p.forceDown && !p.forceUp)
      {a, b} = 2'b01;
    else if (p.forceMidRail && !p.forceUp && !p.forceDown)
      {a, b, mid} = 3'b001;
    return {21'h0, a & p.upEnable, b & p.downEnable, mid};
  endfunction

  function automatic int meas_len(input int code);
    return code < 4 ? 1 << code : 1 << (code + 1);
  endfunction

  // ====================
  // Bus and checks
  task automatic check_word(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    @(negedge clk_sys);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge clk_sys);
    regWrEn = 1'b0;
  endtask

  task automatic rd(input logic [4:0] a);
    @(negedge clk_sys);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge clk_sys);
    regRdEn = 1'b0;
    rdWord = regRdValid ? regRdData : 24'hxxxxxx;
  endtask

  task automatic pulse_lost(input logic exp);
    @(negedge clk_sys);
    lockLost = 1'b1;
    @(negedge clk_sys);
    lockLost = 1'b0;
    seen = relockRequest;
    repeat (2) @(negedge clk_sys) seen = seen | relockRequest;
    check_word({23'h0, seen}, {23'h0, exp});
  endtask

  task automatic finish_test;
    $display("mismatches %0d, comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Run is near 1800 cycles; the limit leaves wide margin
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    finish_test;
  end

  // ====================
  // Scenarios
  initial
  begin
    {rst_b, regWrEn, regRdEn, pfdUpRaw, pfdDownRaw, lockLost, lockRegained} = 7'h0;
    {measStart, refDivTick, modulatorTypeB, regAddr, regWrData} = 32'h0;
    rnd = 32'ha447;
    err_count = 0;
    samples_checked = 0;
    repeat (6) @(negedge clk_sys);
    rst_b = 1'b1;
    rd(pacd_pkg::ADDR_CAL);
    check_word(rdWord, 24'h002046);
    rd(pacd_pkg::ADDR_PD);
    check_word(rdWord, 24'h078061);
    rd(pacd_pkg::ADDR_EXACT);
    check_word(rdWord, 24'h000000);
    wr(5'h0d, 24'hffffff);
    rd(5'h0d);
    check_word(rdWord, 24'h000000);
    for (i = 0; i < 12; i++)
    begin
      rnd = xs(rnd);
      w = rnd[23:0] & 24'hfffe7f;
      wr(5'h0a + i % 3, w);
      rd(5'h0a + i % 3);
      check_word(rdWord, w);
    end
    for (n = 0; n < 64; n++)
    begin
      w = {12'h078, n[5:3], 2'b00, n[2:0], 4'h1};
      wr(pacd_pkg::ADDR_PD, w);
      rnd = xs(rnd);
      {pfdUpRaw, pfdDownRaw} = rnd[1:0];
      repeat (3) @(negedge clk_sys);
      w = pump_exp(w, rnd[1], rnd[0]);
      check_word({21'h0, detectorUpOutput, detectorDownOutput, pumpMidRail}, w);
    end
    for (n = 0; n < 8; n++)
    begin
      wr(pacd_pkg::ADDR_CAL, 24'h002040 | n);
      @(negedge clk_sys) measStart = 1'b1;
      @(negedge clk_sys) measStart = 1'b0;
      i = 0;
      while (i < 300 && measDone !== 1'b1)
      begin
        // One tick per two cycles stands for a divider ratio above one
        @(negedge clk_sys) refDivTick = 1'b1;
        @(negedge clk_sys) refDivTick = 1'b0;
        i++;
      end
      check_word(i, meas_len(n));
    end
    // Only the longest code at this tick rate clears the minimum window
    check_word({23'h0, 2 * i > pacd_pkg::MEAS_MIN_CYCLES}, 24'h000001);
    wr(pacd_pkg::ADDR_CAL, 24'h002846);
    @(negedge clk_sys) measStart = 1'b1;
    @(negedge clk_sys) measStart = 1'b0;
    repeat (2) @(negedge clk_sys);
    check_word({22'h0, calEnable, measBusy}, 24'h000000);
    for (n = 0; n < 4; n++)
    begin
      wr(pacd_pkg::ADDR_CAL, 24'h000046 | (n << 13));
      repeat (4) @(negedge clk_sys);
      check_word({23'h0, calEnable}, 24'h000001);
      i = 0;
      repeat (64) @(negedge clk_sys) i += calClockTick;
      check_word(i, divs[n]);
    end
    wr(pacd_pkg::ADDR_CAL, 24'h022046);
    pulse_lost(1'b1);
    pulse_lost(1'b0);
    @(negedge clk_sys) lockRegained = 1'b1;
    @(negedge clk_sys) lockRegained = 1'b0;
    pulse_lost(1'b1);
    @(negedge clk_sys) lockRegained = 1'b1;
    @(negedge clk_sys) lockRegained = 1'b0;
    wr(pacd_pkg::ADDR_CAL, 24'h002046);
    pulse_lost(1'b0);
    for (m = 0; m < 2; m++)
    begin
      modulatorTypeB = m[0];
      for (n = 0; n < 6; n++)
      begin
        rnd = xs(rnd);
        w = n == 0 ? 24'h0 : n == 1 ? 24'h1 : n == 2 ? 24'h2 : n == 3 ? 24'hffffff : rnd[23:0];
        wr(pacd_pkg::ADDR_EXACT, w);
        repeat (3) @(negedge clk_sys);
        check_word(channelCount, w);
        check_word({22'h0, exactFreqEnable, exactFreqInvalid}, {22'h0, m[0] && w > 1, w == 1});
      end
    end
    finish_test;
  end
endmodule
